// ==== core/ecu_cfg.svh ====
`ifndef ECU_CFG_SVH
`define ECU_CFG_SVH

// register byte addresses
`define ECU_OFS_CTRL 6'h00
`define ECU_OFS_RES_LOW 6'h04
`define ECU_OFS_RES_HIGH 6'h08
`define ECU_OFS_FLAG 6'h0c
`define ECU_OFS_ENABLE 6'h10
`define ECU_OFS_DIR 6'h14
`define ECU_OFS_PORT 6'h18
`define ECU_OFS_TIMER 6'h1c
`define ECU_OFS_TIMER_CTRL 6'h20

// capture mode field codes
`define ECU_MODE_OFF 4'h0
`define ECU_MODE_FALL 4'h4
`define ECU_MODE_RISE 4'h5
`define ECU_MODE_RISE4 4'h6
`define ECU_MODE_RISE16 4'h7

// field positions
`define ECU_FLAG_WRAP 0
`define ECU_FLAG_CAPTURE 2
`define ECU_PIN_BIT 2
`define ECU_TIMER_RUN_BIT 0

// reset values
`define ECU_CTRL_RESET 4'h0
`define ECU_FLAG_RESET 3'h0
`define ECU_ENABLE_RESET 3'h0
`define ECU_DIR_RESET 1'b1
`define ECU_LATCH_RESET 1'b0
`define ECU_TIMER_RESET 16'h0000
`define ECU_RUN_RESET 1'b0
`define ECU_PRESC_RESET 4'h0

// prescaler terminal masks
`define ECU_PRESC_MASK4 4'h3
`define ECU_PRESC_MASK16 4'hf

`endif

// ==== core/ecu_pin.sv ====
`timescale 1ns/10ps
`include "ecu_cfg.svh"
module ecu_pin (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic dir_input,
	input wire logic latch_we,
	input wire logic latch_d,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	output logic level,
	output logic rise,
	output logic fall
);

	logic prev;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= `ECU_LATCH_RESET;
		end else if (latch_we) begin
			pin_out <= latch_d;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_oe_n <= 1'b1;
		end else begin
			pin_oe_n <= dir_input;
		end
	end

	// a driven pin sees its own latch, so port writes make edges
	assign level = pin_oe_n ? pin_in : pin_out;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
		end else begin
			prev <= level;
		end
	end

	assign rise = level && !prev;
	assign fall = !level && prev;

endmodule

// ==== core/ecu_pkg.sv ====
package ecu_pkg;

	typedef enum logic [2:0] {
		ecu_kind_off,
		ecu_kind_fall,
		ecu_kind_rise,
		ecu_kind_rise4,
		ecu_kind_rise16,
		ecu_kind_other
	} ecu_kind_t;

endpackage

// ==== core/ecu_timer.sv ====
`timescale 1ns/10ps
`include "ecu_cfg.svh"
module ecu_timer (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic load,
	input wire logic [15:0] load_value,
	output logic [15:0] count,
	output logic wrap
);

	// companion count, one step per clock while run is set, loaded by a timer write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= `ECU_TIMER_RESET;
		end else if (load) begin
			count <= load_value;
		end else if (run) begin
			count <= 16'(count + 16'h0001);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrap <= 1'b0;
		end else begin
			wrap <= run && !load && (count == 16'hffff);
		end
	end

endmodule

// ==== core/ecu_top.sv ====
`timescale 1ns/10ps
`include "ecu_cfg.svh"
// Function
// - a qualifying pin event copies the full 16-bit timer into result high and low
// - mode field selects falling, rising, every fourth or every sixteenth rising edge
// - each capture sets the capture flag, bit 2; it stays until software clears it
// - a later capture overwrites an unread result with the new timer value
// - with the pin driven as output, a port write that changes it can capture
// - changing the capture mode may set the flag without a real pin event
// - the prescaler has exactly four settings, chosen by the same mode field
// - prescaler counter is held clear while off or in any non-capture mode
// - every reset clears the prescaler counter
// - a direct switch between prescaler settings may raise the capture flag
// - a direct switch between settings keeps the prescaler count as it was
module ecu_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic capture_pin_in,
	output wire logic capture_pin_out,
	output wire logic capture_pin_oe_n,
	output logic irq
);

	logic [3:0] capture_mode_field;
	logic [2:0] peripheral_flag_register;
	logic [2:0] peripheral_enable_register;
	logic port_c_direction;
	logic timer_run;
	logic [15:0] capture_result;
	logic [3:0] presc_cnt;
	logic [2:0] flag_seen;
	logic [15:0] timer_count;
	logic timer_wrap;
	logic pin_level;
	logic pin_rise;
	logic pin_fall;
	ecu_pkg::ecu_kind_t kind;
	ecu_pkg::ecu_kind_t new_kind;
	logic is_capture;
	logic new_is_capture;
	logic capture_hit;
	logic mode_glitch;
	logic acc;
	logic acc_wr;
	logic acc_rd;
	logic wr_ctrl;
	logic wr_enable;
	logic wr_dir;
	logic wr_port;
	logic wr_timer;
	logic wr_timer_ctrl;
	logic rd_flag;
	logic [15:0] timer_load;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic [2:0] next_flag;
	logic [31:0] rd_mux;

	// fixed code per setting, all else is non-capture
	function automatic ecu_pkg::ecu_kind_t decode_mode(input logic [3:0] code);
		ecu_pkg::ecu_kind_t k;
		k = ecu_pkg::ecu_kind_other;
		case (code)
			`ECU_MODE_OFF: k = ecu_pkg::ecu_kind_off;
			`ECU_MODE_FALL: k = ecu_pkg::ecu_kind_fall;
			`ECU_MODE_RISE: k = ecu_pkg::ecu_kind_rise;
			`ECU_MODE_RISE4: k = ecu_pkg::ecu_kind_rise4;
			`ECU_MODE_RISE16: k = ecu_pkg::ecu_kind_rise16;
			default: k = ecu_pkg::ecu_kind_other;
		endcase
		return k;
	endfunction

	function automatic logic capture_kind(input ecu_pkg::ecu_kind_t k);
		capture_kind = (k == ecu_pkg::ecu_kind_fall) || (k == ecu_pkg::ecu_kind_rise) ||
			(k == ecu_pkg::ecu_kind_rise4) || (k == ecu_pkg::ecu_kind_rise16);
	endfunction

	// byte-lane merge for the 16-bit wide timer register
	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] m;
		m = old_v;
		if (be[0]) begin
			m[7:0] = wd[7:0];
		end
		if (be[1]) begin
			m[15:8] = wd[15:8];
		end
		return m;
	endfunction

	ecu_timer u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(timer_run),
		.load(wr_timer),
		.load_value(timer_load),
		.count(timer_count),
		.wrap(timer_wrap)
	);

	ecu_pin u_pin (
		.mclk(mclk),
		.rst_n(rst_n),
		.dir_input(port_c_direction),
		.latch_we(wr_port),
		.latch_d(avs_writedata[`ECU_PIN_BIT]),
		.pin_in(capture_pin_in),
		.pin_out(capture_pin_out),
		.pin_oe_n(capture_pin_oe_n),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// bus: one wait cycle, then the request is taken
	assign acc = (avs_read || avs_write) && !avs_waitrequest;
	assign acc_wr = acc && avs_write;
	assign acc_rd = acc && avs_read;
	assign wr_ctrl = acc_wr && (avs_address == `ECU_OFS_CTRL) && avs_byteenable[0];
	assign wr_enable = acc_wr && (avs_address == `ECU_OFS_ENABLE) && avs_byteenable[0];
	assign wr_dir = acc_wr && (avs_address == `ECU_OFS_DIR) && avs_byteenable[0];
	assign wr_port = acc_wr && (avs_address == `ECU_OFS_PORT) && avs_byteenable[0];
	assign wr_timer = acc_wr && (avs_address == `ECU_OFS_TIMER) && (|avs_byteenable[1:0]);
	assign wr_timer_ctrl = acc_wr && (avs_address == `ECU_OFS_TIMER_CTRL) &&
		avs_byteenable[0];
	assign rd_flag = acc_rd && (avs_address == `ECU_OFS_FLAG);
	assign timer_load = merge16(timer_count, avs_writedata, avs_byteenable);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		if (avs_address == `ECU_OFS_CTRL) begin
			rd_mux[3:0] = capture_mode_field;
		end else if (avs_address == `ECU_OFS_RES_LOW) begin
			rd_mux[7:0] = capture_result[7:0];
		end else if (avs_address == `ECU_OFS_RES_HIGH) begin
			rd_mux[7:0] = capture_result[15:8];
		end else if (avs_address == `ECU_OFS_FLAG) begin
			rd_mux[2:0] = peripheral_flag_register;
		end else if (avs_address == `ECU_OFS_ENABLE) begin
			rd_mux[2:0] = peripheral_enable_register;
		end else if (avs_address == `ECU_OFS_DIR) begin
			rd_mux[`ECU_PIN_BIT] = port_c_direction;
		end else if (avs_address == `ECU_OFS_PORT) begin
			rd_mux[`ECU_PIN_BIT] = pin_level;
		end else if (avs_address == `ECU_OFS_TIMER) begin
			rd_mux[15:0] = timer_count;
		end else if (avs_address == `ECU_OFS_TIMER_CTRL) begin
			rd_mux[`ECU_TIMER_RUN_BIT] = timer_run;
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	// data is loaded as waitrequest drops, so it stands at the taking edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end

	// only the flag bits returned to software are cleared by the read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_seen <= `ECU_FLAG_RESET;
		end else if (avs_read && avs_waitrequest) begin
			flag_seen <= (avs_address == `ECU_OFS_FLAG) ? peripheral_flag_register : 3'h0;
		end
	end

	// software-visible configuration
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			capture_mode_field <= `ECU_CTRL_RESET;
		end else if (wr_ctrl) begin
			capture_mode_field <= avs_writedata[3:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_enable_register <= `ECU_ENABLE_RESET;
		end else if (wr_enable) begin
			peripheral_enable_register <= avs_writedata[2:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_c_direction <= `ECU_DIR_RESET;
		end else if (wr_dir) begin
			port_c_direction <= avs_writedata[`ECU_PIN_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timer_run <= `ECU_RUN_RESET;
		end else if (wr_timer_ctrl) begin
			timer_run <= avs_writedata[`ECU_TIMER_RUN_BIT];
		end
	end

	// event selection
	assign kind = decode_mode(capture_mode_field);
	assign new_kind = decode_mode(avs_writedata[3:0]);
	assign is_capture = capture_kind(kind);
	assign new_is_capture = capture_kind(new_kind);

	always_comb begin
		capture_hit = 1'b0;
		case (kind)
			ecu_pkg::ecu_kind_fall: capture_hit = pin_fall;
			ecu_pkg::ecu_kind_rise: capture_hit = pin_rise;
			ecu_pkg::ecu_kind_rise4: begin
				capture_hit = pin_rise &&
					((presc_cnt & `ECU_PRESC_MASK4) == `ECU_PRESC_MASK4);
			end
			ecu_pkg::ecu_kind_rise16: begin
				capture_hit = pin_rise && (presc_cnt == `ECU_PRESC_MASK16);
			end
			default: capture_hit = 1'b0;
		endcase
	end

	// prescaler: cleared by reset and outside capture, kept across a switch
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			presc_cnt <= `ECU_PRESC_RESET;
		end else if (!is_capture) begin
			presc_cnt <= `ECU_PRESC_RESET;
		end else if (pin_rise && ((kind == ecu_pkg::ecu_kind_rise4) ||
			(kind == ecu_pkg::ecu_kind_rise16))) begin
			presc_cnt <= 4'(presc_cnt + 4'h1);
		end
	end

	// direct switch between two capture settings raises a false flag
	assign mode_glitch = wr_ctrl && is_capture && new_is_capture &&
		(avs_writedata[3:0] != capture_mode_field);

	// result pair holds the latest capture, older one is lost
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			capture_result <= `ECU_TIMER_RESET;
		end else if (capture_hit) begin
			capture_result <= timer_count;
		end
	end

	// sticky flags, read clears, a new event wins over the clear
	always_comb begin
		flag_set = 3'h0;
		flag_set[`ECU_FLAG_CAPTURE] = capture_hit || mode_glitch;
		flag_set[`ECU_FLAG_WRAP] = timer_wrap;
		flag_clr = rd_flag ? flag_seen : 3'h0;
		next_flag = (peripheral_flag_register & ~flag_clr) | flag_set;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_flag_register <= `ECU_FLAG_RESET;
		end else begin
			peripheral_flag_register <= next_flag;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_flag & peripheral_enable_register);
		end
	end

endmodule

// ==== test/ecu_asserts.sv ====
`timescale 1ns/10ps
`include "ecu_cfg.svh"
module ecu_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic capture_pin_in,
	input wire logic capture_pin_out,
	input wire logic capture_pin_oe_n,
	input wire logic irq
);
	logic [1:0] en;
	logic [1:0] quiet;
	logic wr_take;
	assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_wr(logic [5:0] a);
		wr_take && avs_address == a;
	endsequence
	sequence s_rd(logic [5:0] a);
		avs_read && !avs_waitrequest && avs_address == a;
	endsequence
	// shadow of enable bits 2 and 0
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			en <= 2'h0;
		end else if (wr_take && avs_address == `ECU_OFS_ENABLE) begin
			en <= {avs_writedata[2], avs_writedata[0]};
		end
	end
	// cycles since the last bus request, saturating
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			quiet <= 2'h0;
		end else if (avs_read || avs_write) begin
			quiet <= 2'h0;
		end else if (quiet != 2'h3) begin
			quiet <= quiet + 2'h1;
		end
	end
	AST_WAIT_DROP: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("waitrequest did not drop");
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	AST_WAIT_IDLE: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low without request");
	AST_DIR: assert property (s_wr(`ECU_OFS_DIR)
		|-> ##2 capture_pin_oe_n == $past(avs_writedata[2], 2))
		else $error("direction not applied");
	AST_DIR_RD: assert property (s_rd(`ECU_OFS_DIR)
		|-> avs_readdata[2] == capture_pin_oe_n) else $error("direction readback wrong");
	AST_LATCH: assert property (s_wr(`ECU_OFS_PORT)
		|=> capture_pin_out == $past(avs_writedata[2])) else $error("port latch not applied");
	AST_UNMAP: assert property (avs_read && !avs_waitrequest && avs_address > 6'h20
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	AST_MASK: assert property (en == 2'h0 && $past(en) == 2'h0 |-> !irq)
		else $error("irq while all enables clear");
	AST_STICKY: assert property (irq && quiet == 2'h3 |=> irq)
		else $error("irq dropped without software access");
endmodule
bind ecu_top ecu_asserts u_chk (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .capture_pin_in,
	.capture_pin_out, .capture_pin_oe_n, .irq);

// ==== test/ecu_edge_src.sv ====
`timescale 1ns/10ps
module ecu_edge_src (
	input wire logic mclk,
	input wire logic level_req,
	input wire logic slow,
	input wire logic pin_oe_n,
	input wire logic pin_out,
	output logic pin_in
);
	logic [2:0] dly;
	initial dly = 3'h0;
	always @(posedge mclk) begin
		dly <= {dly[1:0], level_req};
	end
	// source lets go while the device drives the pin
	assign pin_in = pin_oe_n ? (slow ? dly[2] : dly[0]) : pin_out;
endmodule

// ==== test/edge_capture_unit_tb.sv ====
`timescale 1ns/10ps
`include "ecu_cfg.svh"
module edge_capture_unit_tb;
	logic mclk, rst_n, avs_read, avs_write, level_req, slow;
	logic avs_waitrequest, pin_in, pin_out, pin_oe_n, irq;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, v;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int err_count, n_tests, seed;
	logic [3:0] modes [4] = '{`ECU_MODE_FALL, `ECU_MODE_RISE, `ECU_MODE_RISE4, `ECU_MODE_RISE16};
	int pre [4] = '{1, 0, 6, 30};
	logic [3:0] others [6] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'hb, 4'hf};
	logic [5:0] ra [9] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h1c, 6'h20, 6'h24};
	ecu_top i_dut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .capture_pin_in(pin_in),
		.capture_pin_out(pin_out), .capture_pin_oe_n(pin_oe_n), .irq);
	ecu_edge_src i_src (.mclk, .level_req, .slow, .pin_oe_n, .pin_out, .pin_in);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 20);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			tally_and_finish();
		end
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic mode(input logic [3:0] m);
		bus(1'b1, `ECU_OFS_CTRL, {28'h0, m});
	endtask
	task automatic tog(input int n);
		repeat (n) begin
			slow <= 1'($random(seed));
			level_req <= !level_req;
			repeat (5) @(posedge mclk);
		end
		repeat (6) @(posedge mclk);
	endtask
	// read data taken at the accepting edge
	always @(posedge mclk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			chk(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
		end
	end
	initial begin
		seed = 91786;
		err_count = 0;
		n_tests = 0;
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		level_req = 1'b0;
		slow = 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (ra[i]) rd(ra[i], (ra[i] == `ECU_OFS_DIR) ? 32'h4 : 32'h0, 32'hffffffff);
		$display("reset values done");
		bus(1'b1, `ECU_OFS_ENABLE, 32'h4);
		for (int k = 0; k < 4; k++) begin
			v = 32'($random(seed)) & 32'hffff;
			bus(1'b1, `ECU_OFS_TIMER, v);
			mode(modes[k]);
			rd(`ECU_OFS_FLAG, 32'h0, 32'h4);
			tog(pre[k]);
			rd(`ECU_OFS_FLAG, 32'h0, 32'h4);
			tog(1);
			chk({31'h0, irq}, 32'h1);
			rd(`ECU_OFS_FLAG, 32'h4, 32'h4);
			rd(`ECU_OFS_RES_LOW, v & 32'hff, 32'hffffffff);
			rd(`ECU_OFS_RES_HIGH, v >> 8, 32'hffffffff);
			chk({31'h0, irq}, 32'h0);
			mode(`ECU_MODE_OFF);
			if (level_req) tog(1);
			$display("mode %h done", modes[k]);
		end
		mode(`ECU_MODE_RISE4);
		tog(4);
		mode(`ECU_MODE_OFF);
		mode(`ECU_MODE_RISE4);
		tog(5);
		rd(`ECU_OFS_FLAG, 32'h0, 32'h4);
		tog(2);
		rd(`ECU_OFS_FLAG, 32'h4, 32'h4);
		mode(`ECU_MODE_OFF);
		tog(1);
		mode(`ECU_MODE_RISE4);
		tog(4);
		mode(`ECU_MODE_RISE16);
		rd(`ECU_OFS_FLAG, 32'h4, 32'h4);
		tog(26);
		rd(`ECU_OFS_FLAG, 32'h0, 32'h4);
		tog(2);
		rd(`ECU_OFS_FLAG, 32'h4, 32'h4);
		foreach (others[i]) begin
			mode(others[i]);
			tog(2);
			rd(`ECU_OFS_FLAG, 32'h0, 32'h4);
		end
		$display("prescaler done");
		bus(1'b1, `ECU_OFS_TIMER, 32'hfffe);
		bus(1'b1, `ECU_OFS_TIMER_CTRL, 32'h1);
		tog(0);
		bus(1'b1, `ECU_OFS_TIMER_CTRL, 32'h0);
		rd(`ECU_OFS_FLAG, 32'h1, 32'h1);
		mode(`ECU_MODE_RISE4);
		tog(10);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`ECU_OFS_CTRL, 32'h0, 32'hffffffff);
		rd(`ECU_OFS_FLAG, 32'h0, 32'hffffffff);
		mode(`ECU_MODE_RISE4);
		tog(6);
		rd(`ECU_OFS_FLAG, 32'h0, 32'h4);
		tog(2);
		rd(`ECU_OFS_FLAG, 32'h4, 32'h4);
		mode(`ECU_MODE_OFF);
		$display("mid-run reset done");
		bus(1'b1, `ECU_OFS_ENABLE, 32'h0);
		mode(`ECU_MODE_RISE);
		bus(1'b1, `ECU_OFS_DIR, 32'h0);
		bus(1'b1, `ECU_OFS_PORT, 32'h4);
		tog(0);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, `ECU_OFS_ENABLE, 32'h4);
		tog(0);
		chk({31'h0, irq}, 32'h1);
		rd(`ECU_OFS_FLAG, 32'h4, 32'h4);
		v = 32'($random(seed)) & 32'hffff;
		bus(1'b1, `ECU_OFS_TIMER, v);
		bus(1'b1, `ECU_OFS_PORT, 32'h0);
		bus(1'b1, `ECU_OFS_PORT, 32'h4);
		tog(0);
		rd(`ECU_OFS_RES_LOW, v & 32'hff, 32'hffffffff);
		rd(`ECU_OFS_RES_HIGH, v >> 8, 32'hffffffff);
		rd(`ECU_OFS_PORT, 32'h4, 32'h4);
		$display("port drive done");
		tally_and_finish();
	end
endmodule
